/* File: mgmt_regs_pkg.sv */
// Constants, layouts and types shared by the indicator and transceiver control registers
`default_nettype none
package mgmt_regs_pkg;

  // ********************************************************
  // Register addresses and reset values
  // ********************************************************
  localparam logic [4:0]  IND_CTRL_ADDR   = 5'h18;
  localparam logic [4:0]  XCVR_CTRL_ADDR  = 5'h19;
  localparam logic [15:0] IND_CTRL_RESET  = 16'h0400;
  localparam logic [15:0] XCVR_CTRL_RESET = 16'h8000;

  // ********************************************************
  // Field layouts, bit 15 first
  // ********************************************************
  typedef struct packed {
    logic [4:0] rsvd_15_11;
    logic [1:0] blink_rate;
    logic       rsvd_8;
    logic       active_level;
    logic [1:0] rsvd_6_5;
    logic       manual_sel;
    logic [1:0] rsvd_3_2;
    logic       manual_value;
    logic       rsvd_0;
  } indicator_control_t;

  typedef struct packed {
    logic       auto_xover;
    logic       force_xover;
    logic       pause_rx;
    logic       pause_tx;
    logic       link_fd100;
    logic [2:0] rsvd_10_8;
    logic       stretch_bypass;
    logic       rsvd_6;
    logic       config_sel;
    logic [4:0] mgmt_addr;
  } transceiver_control_t;

  // Status handed in by the transceiver core, same clock domain
  typedef struct packed {
    logic       link_up;
    logic       activity;
    logic       an_complete;
    logic       hcd_100tx;
    logic       hcd_full_duplex;
    logic [1:0] local_pause;
    logic [1:0] partner_pause;
  } core_status_t;

  // ********************************************************
  // Management frame format
  // ********************************************************
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [5:0] PREAMBLE_LEN  = 6'h20;
  localparam logic [4:0] HDR_LAST      = 5'h0B;
  localparam logic [4:0] WR_LAST       = 5'h11;
  localparam logic [4:0] RD_LAST_DATA  = 5'h10;
  localparam int unsigned PAUSE_SYM    = 0;
  localparam int unsigned PAUSE_ASYM   = 1;

  // ********************************************************
  // Blink timing
  // ********************************************************
  localparam int unsigned CLK_HZ              = 20_000_000;
  localparam int unsigned BLINK_UNIT_MS       = 50;
  localparam int unsigned BLINK_TICK_CYCLES_DEF = CLK_HZ / 1000 * BLINK_UNIT_MS;
  localparam int unsigned BLINK_0_MS          = 50;
  localparam int unsigned BLINK_1_MS          = 100;
  localparam int unsigned BLINK_2_MS          = 200;
  localparam int unsigned BLINK_3_MS          = 500;
  localparam logic [3:0]  BLINK_0_TICKS       = 4'(BLINK_0_MS / BLINK_UNIT_MS);
  localparam logic [3:0]  BLINK_1_TICKS       = 4'(BLINK_1_MS / BLINK_UNIT_MS);
  localparam logic [3:0]  BLINK_2_TICKS       = 4'(BLINK_2_MS / BLINK_UNIT_MS);
  localparam logic [3:0]  BLINK_3_TICKS       = 4'(BLINK_3_MS / BLINK_UNIT_MS);

endpackage
`default_nettype wire

/* File: link_indicator_drive.sv */
// Link indicator pin driver: blink timer, pulse stretching, level and manual forcing
`default_nettype none
module link_indicator_drive import mgmt_regs_pkg::*; #(
  parameter int unsigned BLINK_TICK_CYCLES = BLINK_TICK_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Settings
  input  wire logic [1:0] blink_rate,
  input  wire logic       active_level,
  input  wire logic       manual_sel,
  input  wire logic       manual_value,
  input  wire logic       stretch_bypass,
  // Core state
  input  wire logic       link_up,
  input  wire logic       activity,
  // Pin
  output logic            link_indicator_pin
);

  // ********************************************************
  // Blink phase timer
  // ********************************************************
  logic [19:0] tick_cnt_q;
  logic [3:0]  phase_cnt_q;
  logic        phase_off_q;
  logic        act_seen_q;
  logic        act_hold_q;
  logic        pin_q;

  wire         tick_done  = (tick_cnt_q == 20'(BLINK_TICK_CYCLES - 1));
  // R1 phase length select
  wire [3:0]   phase_len  = (blink_rate == 2'h0) ? BLINK_0_TICKS :
                            (blink_rate == 2'h1) ? BLINK_1_TICKS :
                            (blink_rate == 2'h2) ? BLINK_2_TICKS : BLINK_3_TICKS;
  // Rate change mid-phase ends the phase early rather than waiting a wrap
  wire         phase_done = tick_done && (phase_cnt_q >= phase_len - 4'h1);
  wire         new_period = phase_done && phase_off_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt_q  <= '0;
      phase_cnt_q <= '0;
      phase_off_q <= 1'b0;
    end else begin
      tick_cnt_q  <= tick_done ? '0 : tick_cnt_q + 20'h1;
      phase_cnt_q <= phase_done ? '0 : (tick_done ? phase_cnt_q + 4'h1 : phase_cnt_q);
      phase_off_q <= phase_done ? !phase_off_q : phase_off_q;
    end
  end

  // ********************************************************
  // Activity stretching and pin level
  // ********************************************************
  // R12 stretch holds activity a full period
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      act_seen_q <= 1'b0;
      act_hold_q <= 1'b0;
    end else begin
      // Capture clears the latch so one event holds exactly one period
      act_seen_q <= new_period ? 1'b0 : (act_seen_q || activity);
      act_hold_q <= new_period ? (act_seen_q || activity) : act_hold_q;
    end
  end

  // R12 bypass shows raw internal state
  wire lamp_on = stretch_bypass ? (link_up && !activity)
                                : (link_up && !(act_hold_q && phase_off_q));
  // R3 active level selects pin sense
  wire normal_level = active_level ? lamp_on : !lamp_on;
  // R4 manual select overrides activity
  wire pin_d = manual_sel ? manual_value : normal_level;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign link_indicator_pin = pin_q;

endmodule
`default_nettype wire

/* File: led_and_phy_control_regs.sv */
// Indicator and transceiver control registers behind the serial management port
`default_nettype none
//Contract
// R1 - blink rate code gives 50/100/200/500 ms
// R2 - active level from strap, write overrides
// R3 - level 0 active low, 1 high
// R4 - manual select drives pin from value
// R5 - manual value bit, read-write, resets 0
// R6 - auto crossover enable, strap default one
// R7 - force crossover swaps receive and transmit pairs
// R8 - pause receive status from advertised bits
// R9 - pause transmit status from advertised bits
// R10 - pause resolution only for full duplex
// R11 - link flag: negotiated 100 full duplex
// R12 - bypass bit skips indicator pulse stretching
// R13 - management address read-only, resets zero
// R14 - reserved bits read zero, ignore writes
module led_and_phy_control_regs import mgmt_regs_pkg::*; #(
  parameter int unsigned BLINK_TICK_CYCLES = BLINK_TICK_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Management serial port
  input  wire logic         mdc,
  input  wire logic         mdio_in,
  output logic              mdio_out,
  output logic              mdio_oe_b,
  // Straps
  input  wire logic         strap_led_level,
  input  wire logic         strap_auto_xover,
  // Transceiver core
  input  wire core_status_t core_status,
  output logic              auto_crossover_enable,
  output logic              force_pair_crossover,
  output logic              indicator_config_sel,
  // Indicator pin
  output logic              link_indicator_pin
);

  typedef enum logic [2:0] {S_PRE, S_START, S_HDR, S_RD, S_WR} mgmt_state_t;

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic       mdc_prev_q;

  // Synchronisers run through reset so the straps are settled when it ends
  always_ff @(posedge clk) begin
    pin_meta_q <= {mdc, mdio_in, strap_led_level, strap_auto_xover};
    pin_sync_q <= pin_meta_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mdc_prev_q <= 1'b0;
    end else begin
      mdc_prev_q <= pin_sync_q[3];
    end
  end

  wire mdc_rise   = pin_sync_q[3] && !mdc_prev_q;
  wire mdio_bit   = pin_sync_q[2];
  wire strap_lvl  = pin_sync_q[1];
  wire strap_xovr = pin_sync_q[0];

  // ********************************************************
  // Frame engine state
  // ********************************************************
  mgmt_state_t          state_q;
  logic [5:0]           ones_q;
  logic [4:0]           cnt_q;
  logic [11:0]          hdr_q;
  logic [15:0]          sh_q;
  logic                 wr_ok_q;
  logic                 out_q;
  logic                 oe_b_q;
  indicator_control_t   ind_q;
  transceiver_control_t xcvr_q;
  logic                 strap_done_q;

  // Header after shift: op[11:10] addr[9:5] reg[4:0]
  wire [11:0] hdr_full  = {hdr_q[10:0], mdio_bit};
  wire [1:0]  hdr_op    = hdr_full[11:10];
  // R13 answers only its own address
  wire        addr_hit  = (hdr_full[9:5] == xcvr_q.mgmt_addr);
  wire        go_read   = addr_hit && (hdr_op == OP_READ);
  wire        go_write  = addr_hit && (hdr_op == OP_WRITE);
  wire [4:0]  reg_sel   = hdr_q[4:0];
  // Unmapped registers read as zero
  wire [15:0] rd_data   = (reg_sel == IND_CTRL_ADDR)  ? ind_q  :
                          (reg_sel == XCVR_CTRL_ADDR) ? xcvr_q : 16'h0000;
  wire [15:0] wr_data   = {sh_q[14:0], mdio_bit};
  wire        wr_fire   = mdc_rise && (state_q == S_WR) && (cnt_q == WR_LAST) && wr_ok_q;
  wire        wr_ind    = wr_fire && (reg_sel == IND_CTRL_ADDR);
  wire        wr_xcvr   = wr_fire && (reg_sel == XCVR_CTRL_ADDR);
  wire indicator_control_t   wr_ind_f  = wr_data;
  wire transceiver_control_t wr_xcvr_f = wr_data;

  // ********************************************************
  // Frame engine: sampled on each management clock rise
  // ********************************************************
  // A full preamble is needed before every frame; no preamble suppression
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= S_PRE;
      ones_q  <= '0;
      cnt_q   <= '0;
      hdr_q   <= '0;
      sh_q    <= '0;
      wr_ok_q <= 1'b0;
      out_q   <= 1'b1;
      oe_b_q  <= 1'b1;
    end else if (mdc_rise) begin
      unique case (state_q)
        S_PRE: begin
          if (mdio_bit) begin
            ones_q <= (ones_q == PREAMBLE_LEN) ? ones_q : ones_q + 6'h1;
          end else begin
            ones_q  <= '0;
            state_q <= (ones_q == PREAMBLE_LEN) ? S_START : S_PRE;
          end
        end
        S_START: begin
          cnt_q   <= '0;
          state_q <= mdio_bit ? S_HDR : S_PRE;
        end
        S_HDR: begin
          hdr_q <= hdr_full;
          cnt_q <= (cnt_q == HDR_LAST) ? '0 : cnt_q + 5'h1;
          if (cnt_q == HDR_LAST) begin
            state_q <= go_read ? S_RD : S_WR;
            wr_ok_q <= go_write;
          end
        end
        S_RD: begin
          cnt_q <= cnt_q + 5'h1;
          if (cnt_q == 5'h0) begin
            out_q  <= 1'b0;
            oe_b_q <= 1'b0;
            sh_q   <= rd_data;
          end else if (cnt_q <= RD_LAST_DATA) begin
            out_q <= sh_q[15];
            sh_q  <= {sh_q[14:0], 1'b0};
          end else begin
            out_q   <= 1'b1;
            oe_b_q  <= 1'b1;
            state_q <= S_PRE;
          end
        end
        S_WR: begin
          sh_q    <= wr_data;
          cnt_q   <= cnt_q + 5'h1;
          state_q <= (cnt_q == WR_LAST) ? S_PRE : S_WR;
        end
      endcase
    end
  end

  // ********************************************************
  // Status resolution
  // ********************************************************
  wire lp = core_status.local_pause[PAUSE_SYM];
  wire la = core_status.local_pause[PAUSE_ASYM];
  wire rp = core_status.partner_pause[PAUSE_SYM];
  wire ra = core_status.partner_pause[PAUSE_ASYM];
  wire an_fd = core_status.an_complete && core_status.hcd_full_duplex;
  // R8 honour received pause frames
  wire pause_rx_d = an_fd && ((lp && rp) || (lp && la && !rp && ra));
  // R9 send pause frames
  wire pause_tx_d = an_fd && ((lp && rp) || (!lp && la && rp && ra));
  // R11 negotiated 100 full duplex link
  wire link_fd100_d = an_fd && core_status.hcd_100tx && core_status.link_up;

  // ********************************************************
  // Register storage
  // ********************************************************
  // Reserved fields are never loaded so they stay at their zero reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ind_q        <= IND_CTRL_RESET;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      // R2 strap caught after reset release
      if (!strap_done_q) begin
        ind_q.active_level <= strap_lvl;
      end
      // R14 only defined fields take writes
      if (wr_ind) begin
        // R1 blink rate store
        ind_q.blink_rate   <= wr_ind_f.blink_rate;
        // R2 write overrides strap
        ind_q.active_level <= wr_ind_f.active_level;
        ind_q.manual_sel   <= wr_ind_f.manual_sel;
        // R5 manual value store
        ind_q.manual_value <= wr_ind_f.manual_value;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      xcvr_q <= XCVR_CTRL_RESET;
    end else begin
      // R10 gated by full duplex above
      xcvr_q.pause_rx   <= pause_rx_d;
      xcvr_q.pause_tx   <= pause_tx_d;
      xcvr_q.link_fd100 <= link_fd100_d;
      // R6 strap sets crossover default
      if (!strap_done_q) begin
        xcvr_q.auto_xover <= strap_xovr;
      end
      // R13 address field takes no write
      if (wr_xcvr) begin
        xcvr_q.auto_xover     <= wr_xcvr_f.auto_xover;
        // R7 force crossover store
        xcvr_q.force_xover    <= wr_xcvr_f.force_xover;
        xcvr_q.stretch_bypass <= wr_xcvr_f.stretch_bypass;
        xcvr_q.config_sel     <= wr_xcvr_f.config_sel;
      end
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign mdio_out              = out_q;
  assign mdio_oe_b             = oe_b_q;
  // R6 enable seen by negotiation
  assign auto_crossover_enable = xcvr_q.auto_xover;
  // R7 pair swap to the line side
  assign force_pair_crossover  = xcvr_q.force_xover;
  assign indicator_config_sel  = xcvr_q.config_sel;

  link_indicator_drive #(
    .BLINK_TICK_CYCLES (BLINK_TICK_CYCLES)
  ) u_indicator (
    .clk                (clk),
    .rst_b              (rst_b),
    .blink_rate         (ind_q.blink_rate),
    .active_level       (ind_q.active_level),
    .manual_sel         (ind_q.manual_sel),
    .manual_value       (ind_q.manual_value),
    .stretch_bypass     (xcvr_q.stretch_bypass),
    .link_up            (core_status.link_up),
    .activity           (core_status.activity),
    .link_indicator_pin (link_indicator_pin)
  );

endmodule
`default_nettype wire

/* File: led_and_phy_control_regs_checker.sv */
// Port checker for the indicator and transceiver control registers
`default_nettype none
module led_and_phy_control_regs_checker import mgmt_regs_pkg::*; #(
  parameter int unsigned BLINK_TICK_CYCLES = BLINK_TICK_CYCLES_DEF
) (
  // Clock, reset, straps
  input wire logic         clk,
  input wire logic         rst_b,
  input wire logic         strap_led_level,
  input wire logic         strap_auto_xover,
  // Serial port
  input wire logic         mdc,
  input wire logic         mdio_in,
  input wire logic         mdio_out,
  input wire logic         mdio_oe_b,
  // Core side and pin
  input wire core_status_t core_status,
  input wire logic         auto_crossover_enable,
  input wire logic         force_pair_crossover,
  input wire logic         indicator_config_sel,
  input wire logic         link_indicator_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  // ****
  // Read answer steps
  // ****
  sequence s_drive_start;
    $fell(mdio_oe_b);
  endsequence
  sequence s_drive_hold;
    (!mdio_oe_b)[*8];
  endsequence
  a_reset_ctrl_out: assert property (!rst_b |=> auto_crossover_enable && !force_pair_crossover)
    else $error("crossover outputs not at reset values");
  a_reset_pin_idle: assert property (!rst_b |=> link_indicator_pin && mdio_oe_b && mdio_out)
    else $error("pin or serial line not idle in reset");
  a_strap_xover: assert property ($rose(rst_b) |=> auto_crossover_enable == strap_auto_xover)
    else $error("crossover enable not taken from strap");
  // Link down, so the pin shows the inactive level of the strap
  a_strap_level: assert property ($rose(rst_b) ##0 (!core_status.link_up)[*3] |->
    link_indicator_pin == !strap_led_level) else $error("indicator level not taken from strap");
  a_ctrl_stable_rd: assert property (disable iff (!rst_b) $past(rst_b) && !mdio_oe_b |->
    $stable(force_pair_crossover) && $stable(indicator_config_sel)) else $error("control moved during read");
  a_idle_line_high: assert property (disable iff (!rst_b) mdio_oe_b |-> mdio_out)
    else $error("serial output not high while released");
  a_answer_hold: assert property (disable iff (!rst_b) s_drive_start |-> !mdio_out ##0 s_drive_hold)
    else $error("read answer too short or turnaround not zero");
  a_answer_end: assert property (disable iff (!rst_b) s_drive_start |-> ##[100:200] mdio_oe_b)
    else $error("read answer not released in time");
endmodule
`default_nettype wire

/* File: mdio_host_model.sv */
// Station management host model driving framed serial accesses
`default_nettype none
module mdio_host_model import mgmt_regs_pkg::*; (
  // Serial port
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe_b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv_en;
  logic drv_bit;
  // Pull-up wins when neither side drives
  assign mdio_in = !mdio_oe_b ? mdio_out : (drv_en ? drv_bit : 1'b1);
  initial begin
    mdc = 1'b0;
    drv_en = 1'b0;
    drv_bit = 1'b1;
  end
  // One bit period; clock stands low between frames
  task automatic cyc(input logic en, input logic b, output logic s);
    drv_en = en;
    drv_bit = b;
    #200 mdc = 1'b1;
    s = mdio_in;
    #200 mdc = 1'b0;
  endtask
  // Full frame with its own preamble; read data sampled one rise after it is put out
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] w;
    logic        s;
    w = {2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    repeat (32) cyc(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      cyc((op == OP_WRITE) || (i >= 18), w[i], s);
      if (i <= 15) rd = {rd[14:0], s};
    end
    drv_en = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: led_and_phy_control_regs_tb.sv */
// Testbench for the indicator and transceiver control registers
`default_nettype none
module led_and_phy_control_regs_tb import mgmt_regs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned TICK = 10;
  logic         clk, rst_b, mdc, mdio_in, mdio_out, mdio_oe_b;
  logic         strap_lvl, strap_ax, auto_x, force_x, cfg_sel, pin;
  core_status_t cs;
  int           n_mismatch = 0;
  int           n_checks = 0;
  int           k;
  int           ph [4] = '{TICK, 2 * TICK, 4 * TICK, 10 * TICK};
  led_and_phy_control_regs #(.BLINK_TICK_CYCLES(TICK)) u_led_and_phy_control_regs (.clk(clk), .rst_b(rst_b),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_b(mdio_oe_b), .strap_led_level(strap_lvl),
    .strap_auto_xover(strap_ax), .core_status(cs), .auto_crossover_enable(auto_x),
    .force_pair_crossover(force_x), .indicator_config_sel(cfg_sel), .link_indicator_pin(pin));
  mdio_host_model u_mdio_host_model (.mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_b(mdio_oe_b));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****
  // Access and compare tasks
  // ****
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    u_mdio_host_model.frame(OP_WRITE, 5'h00, ra, d, x);
    repeat (4) @(negedge clk);
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] x;
    u_mdio_host_model.frame(OP_READ, 5'h00, ra, 16'h0000, x);
    chk(nm, exp, x);
    @(negedge clk);
  endtask
  task automatic count_low(input int n);
    k = 0;
    repeat (n) begin
      if (pin === 1'b0) k++;
      @(negedge clk);
    end
  endtask
  task automatic pulse();
    cs.activity = 1'b1;
    @(negedge clk);
    cs.activity = 1'b0;
  endtask
  // Pause resolution as {receive, transmit}; bit 1 asymmetric, bit 0 symmetric
  function automatic logic [1:0] pause_res(input logic [1:0] l, input logic [1:0] p);
    if (l[PAUSE_SYM] && p[PAUSE_SYM]) return 2'h3;
    if (l == 2'h2 && p == 2'h3) return 2'h1;
    if (l == 2'h3 && p == 2'h2) return 2'h2;
    return 2'h0;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
  // ****
  // Test sequence
  // ****
  initial begin
    logic [15:0] x;
    rst_b = 1'b0;
    strap_lvl = 1'b1;
    strap_ax = 1'b0;
    cs = '0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    rd_chk("ind_reset", IND_CTRL_ADDR, 16'h0480);
    rd_chk("xcvr_reset", XCVR_CTRL_ADDR, 16'h0000);
    wr(IND_CTRL_ADDR, 16'hFFFF);
    wr(XCVR_CTRL_ADDR, 16'hFFFF);
    rd_chk("ind_ones", IND_CTRL_ADDR, 16'h0692);
    rd_chk("xcvr_ones", XCVR_CTRL_ADDR, 16'hC0A0);
    chk("ctrl_out", 16'h0007, {13'h0000, auto_x, force_x, cfg_sel});
    chk("pin_manual1", 16'h0001, 16'(pin));
    // Frame for another station address must be ignored
    u_mdio_host_model.frame(OP_WRITE, 5'h01, IND_CTRL_ADDR, 16'h0000, x);
    @(negedge clk);
    rd_chk("other_addr", IND_CTRL_ADDR, 16'h0692);
    rd_chk("unmapped", 5'h1F, 16'h0000);
    wr(IND_CTRL_ADDR, 16'h0090);
    chk("pin_manual0", 16'h0000, 16'(pin));
    cs.link_up = 1'b1;
    wr(IND_CTRL_ADDR, 16'h0080);
    chk("pin_high_on", 16'h0001, 16'(pin));
    wr(IND_CTRL_ADDR, 16'h0000);
    chk("pin_low_on", 16'h0000, 16'(pin));
    cs.link_up = 1'b0;
    repeat (3) @(negedge clk);
    chk("pin_low_off", 16'h0001, 16'(pin));
    wr(XCVR_CTRL_ADDR, 16'h0000);
    chk("ctrl_clear", 16'h0000, {13'h0000, auto_x, force_x, cfg_sel});
    cs = '{link_up: 1'b1, an_complete: 1'b1, hcd_100tx: 1'b1, hcd_full_duplex: 1'b1, default: '0};
    for (int l = 0; l < 4; l++) begin
      for (int p = 0; p < 4; p++) begin
        cs.local_pause = 2'(l);
        cs.partner_pause = 2'(p);
        rd_chk("status", XCVR_CTRL_ADDR, {2'b00, pause_res(2'(l), 2'(p)), 1'b1, 11'h000});
      end
    end
    cs.hcd_full_duplex = 1'b0;
    rd_chk("half_duplex", XCVR_CTRL_ADDR, 16'h0000);
    cs.hcd_full_duplex = 1'b1;
    cs.hcd_100tx = 1'b0;
    rd_chk("not_100tx", XCVR_CTRL_ADDR, 16'h3000);
    cs.activity = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(IND_CTRL_ADDR, 16'h0080 | 16'(c << 9));
      repeat (4 * ph[c]) @(negedge clk);
      count_low(8 * ph[c]);
      chk("blink_low", 16'(4 * ph[c]), 16'(k));
    end
    cs.activity = 1'b0;
    wr(IND_CTRL_ADDR, 16'h0080);
    repeat (40) @(negedge clk);
    pulse();
    count_low(60);
    chk("stretched", 16'(ph[0]), 16'(k));
    wr(XCVR_CTRL_ADDR, 16'h0080);
    repeat (40) @(negedge clk);
    pulse();
    count_low(20);
    chk("bypassed", 16'h0001, 16'(k));
    final_report();
  end
endmodule
bind led_and_phy_control_regs led_and_phy_control_regs_checker #(.BLINK_TICK_CYCLES(BLINK_TICK_CYCLES))
  u_led_and_phy_control_regs_checker (.clk(clk), .rst_b(rst_b), .strap_led_level(strap_led_level),
  .strap_auto_xover(strap_auto_xover), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
  .mdio_oe_b(mdio_oe_b), .core_status(core_status), .auto_crossover_enable(auto_crossover_enable),
  .force_pair_crossover(force_pair_crossover), .indicator_config_sel(indicator_config_sel),
  .link_indicator_pin(link_indicator_pin));
`default_nettype wire
